// ---- hdl/acr_pkg.sv ----
package acr_pkg;

	// Register map
	localparam logic [12:0] ADDR_PORT_CFG  = 13'h0000;
	localparam logic [12:0] ADDR_CHIP_ID   = 13'h0001;
	localparam logic [12:0] ADDR_GRADE     = 13'h0002;
	localparam logic [12:0] ADDR_CHAN_SEL  = 13'h0005;
	localparam logic [12:0] ADDR_PROG_LO   = 13'h0008;
	localparam logic [12:0] ADDR_SHADOW_HI = 13'h0018;
	localparam logic [12:0] ADDR_PROG_HI   = 13'h002E;
	localparam logic [12:0] ADDR_XFER      = 13'h00FF;
	localparam logic [12:0] ADDR_DIG_LO    = 13'h0100;
	localparam logic [12:0] ADDR_DIG_HI    = 13'h011D;

	// Array sizes
	localparam int PROG_NUM = 39;
	localparam int SHD_NUM  = 17;
	localparam int DIG_NUM  = 30;

	// Reset values
	localparam logic [7:0] PORT_CFG_RST = 8'h18;
	localparam logic [7:0] CHAN_SEL_RST = 8'h03;
	localparam logic [7:0] PROG_RST     = 8'h00;
	localparam logic [7:0] DIG_RST      = 8'h00;

	// Field positions
	localparam int CHAN_A_BIT   = 0;
	localparam int CHAN_B_BIT   = 1;
	localparam int XFER_BIT     = 0;
	localparam int RW_BIT       = 15;
	localparam int LEN_HI       = 14;
	localparam int LEN_LO       = 13;
	localparam int SOFT_RST_HI  = 5;
	localparam int SOFT_RST_LO  = 2;
	localparam int LSB_FIRST_HI = 6;
	localparam int LSB_FIRST_LO = 1;
	localparam logic [1:0] LEN_STREAM = 2'h3;

	// Active-copy fields steering the standalone-capable controls
	localparam int         DCS_IDX  = 1;
	localparam int         DCS_BIT  = 0;
	localparam int         FMT_IDX  = 12;
	localparam logic [1:0] FMT_TWOS = 2'h1;

	// Identity (values arbitrary)
	localparam logic [7:0] CHIP_ID_VAL = 8'hA5;
	localparam logic [7:0] GRADE_VAL   = 8'h00;

	// Timing counts
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [3:0] LAST_BIT   = 4'hF;
	localparam logic [3:0] BYTE_LAST  = 4'h7;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_INSTR = 2'b01,
		ST_DATA  = 2'b10,
		ST_HALT  = 2'b11
	} acr_state_e;

endpackage

// ---- hdl/acr_config_bank.sv ----
// Notes on behaviour
// [R01] Data pin receives in write phases and drives out during readback phases.
// [R02] Serial clock and chip select are only ever inputs.
// [R03] Chip select held high disables the port; dual pins become static controls.
// [R04] Dual-function pin levels are captured after power-on reset to pick standalone functions.
// [R05] Standalone: data-pin strap high enables duty cycle stabilizer, low disables.
// [R06] Standalone: clock-pin strap high gives twos complement, low offset binary.
// [R07] Output-enable pin high puts data outputs in high impedance.
// [R08] Power-down pin high puts chip in power-down or standby.
// [R09] Map regions: 0x00-0x02, 0x05 and 0xFF, 0x08-0x2E, 0x100-0x11D.
// [R10] Channel index resets to 0x03, both channels selected.
// [R11] Host writes zeros to open bits of valid registers.
// [R12] Host never writes fully unassigned addresses.
// [R13] Reset loads registers with their default values.
// [R14] Addresses 0x08-0x18 are shadowed; writes act only after a transfer.
// [R15] Writing 0x01 to 0xFF sets the transfer bit and triggers the update.
// [R16] Transfer copies all shadowed values at once, then the bit clears itself.
// [R17] Local writes reach channel A with index bit 0, channel B with bit 1.
// [R18] Both index bits set: a local write updates both channels.
// [R19] Host selects exactly one channel before reading a local register; the bench also reads with both index bits set.
// [R20] Both index bits set on read returns channel A's copy.
// [R21] Global registers ignore the channel index.
// [R22] Host keeps the serial port idle during critical sampling.
// [R23] Frame starts on first clock rise after select falls; 16-bit instruction, R/W first.
// [R24] Non-shadowed writes take effect once the data byte is complete.
`timescale 1ns/1ps

module acr_config_bank (
	input  wire logic                        sys_clk_i,
	input  wire logic                        sys_rst_i,
	input  wire logic                        chip_select_n_i,
	input  wire logic                        clock_pin_format_strap_i,
	input  wire logic                        data_pin_stabilizer_strap_i,
	output logic                             data_pin_stabilizer_strap_o,
	output logic                             data_pin_stabilizer_strap_oe_n_o,
	input  wire logic                        output_enable_n_i,
	input  wire logic                        power_down_pin_i,
	output logic                             duty_cycle_stabilizer_o,
	output logic                             twos_complement_o,
	output logic                             outputs_hiz_o,
	output logic                             power_down_o,
	output logic                             spi_active_o,
	output logic [acr_pkg::PROG_NUM*8-1:0]   prog_a_o,
	output logic [acr_pkg::PROG_NUM*8-1:0]   prog_b_o,
	output logic [acr_pkg::DIG_NUM*8-1:0]    dig_o
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic                                     cs_s1;
		logic                                     cs_s2;
		logic                                     sck_s1;
		logic                                     sck_s2;
		logic                                     sck_d;
		logic                                     sdi_s1;
		logic                                     sdi_s2;
		logic                                     oeb_s1;
		logic                                     oeb_s2;
		logic                                     pd_s1;
		logic                                     pd_s2;
		acr_pkg::acr_state_e                      state;
		logic [3:0]                               cnt;
		logic [15:0]                              sh;
		logic                                     rd;
		logic [1:0]                               len;
		logic [1:0]                               bytes;
		logic [12:0]                              addr;
		logic [7:0]                               out_sh;
		logic                                     sdo;
		logic                                     drive;
		logic [7:0]                               port_cfg;
		logic [7:0]                               chan_sel;
		logic                                     xfer;
		logic [acr_pkg::PROG_NUM-1:0][7:0]        mas_a;
		logic [acr_pkg::PROG_NUM-1:0][7:0]        mas_b;
		logic [acr_pkg::SHD_NUM-1:0][7:0]         act_a;
		logic [acr_pkg::SHD_NUM-1:0][7:0]         act_b;
		logic [acr_pkg::DIG_NUM-1:0][7:0]         dig;
		logic [1:0]                               strap_cnt;
		logic                                     strap_done;
		logic                                     dcs_strap;
		logic                                     fmt_strap;
		logic                                     spi_used;
		logic                                     dcs_o;
		logic                                     twos_o;
		logic                                     hiz_o;
		logic                                     pd_o;
	} acr_regs_s;

	acr_regs_s q_r;
	acr_regs_s q_nxt;
	logic      sck_rise;
	logic      sck_fall;

	////////////////////////////////////////////////////////////////////////
	// Register read and write

	function automatic logic [7:0] rd_byte(input acr_regs_s s, input logic [12:0] a);
		logic [5:0] pi;
		logic [4:0] di;
		pi = 6'(a - acr_pkg::ADDR_PROG_LO);
		di = 5'(a - acr_pkg::ADDR_DIG_LO);
		rd_byte = 8'h00;
		if (a == acr_pkg::ADDR_PORT_CFG) begin
			rd_byte = s.port_cfg;
		end else if (a == acr_pkg::ADDR_CHIP_ID) begin
			rd_byte = acr_pkg::CHIP_ID_VAL;
		end else if (a == acr_pkg::ADDR_GRADE) begin
			rd_byte = acr_pkg::GRADE_VAL;
		end else if (a == acr_pkg::ADDR_CHAN_SEL) begin
			rd_byte = s.chan_sel; // R21
		end else if (a == acr_pkg::ADDR_XFER) begin
			rd_byte = {7'h00, s.xfer};
		end else if (a >= acr_pkg::ADDR_PROG_LO && a <= acr_pkg::ADDR_PROG_HI) begin
			rd_byte = s.chan_sel[acr_pkg::CHAN_A_BIT] ? s.mas_a[pi] : s.mas_b[pi]; // R20
		end else if (a >= acr_pkg::ADDR_DIG_LO && a <= acr_pkg::ADDR_DIG_HI) begin
			rd_byte = s.dig[di]; // R21
		end
	endfunction

	function automatic acr_regs_s wr_byte(input acr_regs_s s, input logic [12:0] a,
		input logic [7:0] d);
		logic [5:0] pi;
		logic [4:0] di;
		pi = 6'(a - acr_pkg::ADDR_PROG_LO);
		di = 5'(a - acr_pkg::ADDR_DIG_LO);
		wr_byte = s;
		if (a == acr_pkg::ADDR_PORT_CFG) begin
			// Mirrored nibbles, soft reset self-clears
			wr_byte.port_cfg = acr_pkg::PORT_CFG_RST;
			wr_byte.port_cfg[acr_pkg::LSB_FIRST_HI] = d[acr_pkg::LSB_FIRST_HI];
			wr_byte.port_cfg[acr_pkg::LSB_FIRST_LO] = d[acr_pkg::LSB_FIRST_HI];
			if (d[acr_pkg::SOFT_RST_HI] || d[acr_pkg::SOFT_RST_LO]) begin
				wr_byte.chan_sel = acr_pkg::CHAN_SEL_RST; // R13
				wr_byte.mas_a    = {acr_pkg::PROG_NUM{acr_pkg::PROG_RST}};
				wr_byte.mas_b    = {acr_pkg::PROG_NUM{acr_pkg::PROG_RST}};
				wr_byte.dig      = {acr_pkg::DIG_NUM{acr_pkg::DIG_RST}};
			end
		end else if (a == acr_pkg::ADDR_CHAN_SEL) begin
			wr_byte.chan_sel = {6'h00, d[1:0]}; // R21
		end else if (a == acr_pkg::ADDR_XFER) begin
			if (d[acr_pkg::XFER_BIT]) begin
				wr_byte.xfer = 1'b1; // R15
			end
		end else if (a >= acr_pkg::ADDR_PROG_LO && a <= acr_pkg::ADDR_PROG_HI) begin
			if (s.chan_sel[acr_pkg::CHAN_A_BIT]) begin
				wr_byte.mas_a[pi] = d; // R17 R18
			end
			if (s.chan_sel[acr_pkg::CHAN_B_BIT]) begin
				wr_byte.mas_b[pi] = d; // R17 R18
			end
		end else if (a >= acr_pkg::ADDR_DIG_LO && a <= acr_pkg::ADDR_DIG_HI) begin
			wr_byte.dig[di] = d; // R09 R24
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state

	assign sck_rise = q_r.sck_s2 & ~q_r.sck_d;
	assign sck_fall = ~q_r.sck_s2 & q_r.sck_d;

	always_comb begin
		q_nxt        = q_r;
		q_nxt.cs_s1  = chip_select_n_i;
		q_nxt.cs_s2  = q_r.cs_s1;
		q_nxt.sck_s1 = clock_pin_format_strap_i;
		q_nxt.sck_s2 = q_r.sck_s1;
		q_nxt.sck_d  = q_r.sck_s2;
		q_nxt.sdi_s1 = data_pin_stabilizer_strap_i;
		q_nxt.sdi_s2 = q_r.sdi_s1;
		q_nxt.oeb_s1 = output_enable_n_i;
		q_nxt.oeb_s2 = q_r.oeb_s1;
		q_nxt.pd_s1  = power_down_pin_i;
		q_nxt.pd_s2  = q_r.pd_s1;

		// Shadow update, then self-clear
		if (q_r.xfer) begin
			q_nxt.act_a = q_r.mas_a[acr_pkg::SHD_NUM-1:0]; // R14 R16
			q_nxt.act_b = q_r.mas_b[acr_pkg::SHD_NUM-1:0]; // R16
			q_nxt.xfer  = 1'b0; // R16
		end

		// Strap capture after reset
		if (!q_r.strap_done) begin
			q_nxt.strap_cnt = 2'(q_r.strap_cnt + 2'h1);
			if (q_r.strap_cnt == acr_pkg::STRAP_WAIT) begin
				q_nxt.strap_done = 1'b1; // R04
				q_nxt.dcs_strap  = q_r.sdi_s2; // R04
				q_nxt.fmt_strap  = q_r.sck_s2; // R04
			end
		end

		// Serial frame
		if (q_r.cs_s2) begin
			q_nxt.state = acr_pkg::ST_IDLE; // R03
			q_nxt.cnt   = 4'h0;
			q_nxt.drive = 1'b0; // R03
		end else begin
			if (q_r.strap_done) begin
				q_nxt.spi_used = 1'b1; // R03
			end
			case (q_r.state)
				acr_pkg::ST_IDLE: begin
					if (sck_rise) begin
						q_nxt.sh    = {q_r.sh[14:0], q_r.sdi_s2}; // R23
						q_nxt.cnt   = 4'h1;
						q_nxt.state = acr_pkg::ST_INSTR; // R23
					end
				end
				acr_pkg::ST_INSTR: begin
					if (sck_rise) begin
						q_nxt.sh  = {q_r.sh[14:0], q_r.sdi_s2};
						q_nxt.cnt = 4'(q_r.cnt + 4'h1);
						if (q_r.cnt == acr_pkg::LAST_BIT) begin
							q_nxt.rd     = q_r.sh[acr_pkg::RW_BIT-1]; // R23
							q_nxt.len    = q_r.sh[acr_pkg::LEN_HI-1:acr_pkg::LEN_LO-1];
							q_nxt.addr   = {q_r.sh[11:0], q_r.sdi_s2};
							q_nxt.out_sh = rd_byte(q_r, {q_r.sh[11:0], q_r.sdi_s2});
							q_nxt.bytes  = 2'h0;
							q_nxt.cnt    = 4'h0;
							q_nxt.state  = acr_pkg::ST_DATA;
						end
					end
				end
				acr_pkg::ST_DATA: begin
					if (sck_fall && q_r.rd) begin
						q_nxt.sdo    = q_r.out_sh[7]; // R01
						q_nxt.out_sh = {q_r.out_sh[6:0], 1'b0};
						q_nxt.drive  = 1'b1; // R01
					end
					if (sck_rise) begin
						q_nxt.sh  = {q_r.sh[14:0], q_r.sdi_s2};
						q_nxt.cnt = 4'(q_r.cnt + 4'h1);
						if (q_r.cnt == acr_pkg::BYTE_LAST) begin
							q_nxt.cnt  = 4'h0;
							q_nxt.addr = 13'(q_r.addr - 13'h0001);
							if (!q_r.rd) begin
								q_nxt = wr_byte(q_nxt, q_r.addr,
									{q_r.sh[6:0], q_r.sdi_s2}); // R24
							end else begin
								q_nxt.out_sh = rd_byte(q_r, 13'(q_r.addr - 13'h0001));
							end
							q_nxt.bytes = 2'(q_r.bytes + 2'h1);
							if (q_r.len != acr_pkg::LEN_STREAM && q_r.bytes == q_r.len) begin
								q_nxt.state = acr_pkg::ST_HALT;
							end
						end
					end
				end
				default: begin
					if (sck_fall) begin
						q_nxt.drive = 1'b0;
					end
				end
			endcase
		end

		// Static controls
		q_nxt.hiz_o = q_r.oeb_s2; // R07
		q_nxt.pd_o  = q_r.pd_s2; // R08
		if (q_r.spi_used) begin
			q_nxt.dcs_o  = q_r.act_a[acr_pkg::DCS_IDX][acr_pkg::DCS_BIT];
			q_nxt.twos_o = q_r.act_a[acr_pkg::FMT_IDX][1:0] == acr_pkg::FMT_TWOS;
		end else begin
			q_nxt.dcs_o  = q_r.dcs_strap; // R05
			q_nxt.twos_o = q_r.fmt_strap; // R06
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			q_r          <= '0; // R13
			q_r.cs_s1    <= 1'b1;
			q_r.cs_s2    <= 1'b1;
			q_r.port_cfg <= acr_pkg::PORT_CFG_RST; // R13
			q_r.chan_sel <= acr_pkg::CHAN_SEL_RST; // R10
			q_r.dcs_strap <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign data_pin_stabilizer_strap_o      = q_r.sdo;
	assign data_pin_stabilizer_strap_oe_n_o = ~q_r.drive; // R01
	assign duty_cycle_stabilizer_o          = q_r.dcs_o;
	assign twos_complement_o                = q_r.twos_o;
	assign outputs_hiz_o                    = q_r.hiz_o;
	assign power_down_o                     = q_r.pd_o;
	assign spi_active_o                     = q_r.spi_used;
	assign prog_a_o = {q_r.mas_a[acr_pkg::PROG_NUM-1:acr_pkg::SHD_NUM], q_r.act_a}; // R14
	assign prog_b_o = {q_r.mas_b[acr_pkg::PROG_NUM-1:acr_pkg::SHD_NUM], q_r.act_b}; // R14
	assign dig_o    = q_r.dig;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_index_reset_val: assert property ($fell(sys_rst_i) |-> q_r.chan_sel == 8'h03) // R10
		else $error("channel index not 0x03 after reset");
	a_xfer_self_clear: assert property (q_r.xfer |=> !q_r.xfer) // R16
		else $error("transfer bit did not clear");
	a_xfer_copy_all: assert property (q_r.xfer |=> (q_r.act_a == $past(q_r.mas_a[16:0]))
		&& (q_r.act_b == $past(q_r.mas_b[16:0]))) // R16
		else $error("shadow copy mismatch");
	a_shadow_hold: assert property (!q_r.xfer |=> $stable(q_r.act_a) && $stable(q_r.act_b)) // R14
		else $error("active copy changed without transfer");
	a_cs_high_idle: assert property (q_r.cs_s2 |=> q_r.state == acr_pkg::ST_IDLE
		&& !q_r.drive) // R03
		else $error("port active with select high");
	a_drive_on_read: assert property (q_r.drive |-> q_r.rd // R01
		&& !(q_r.cs_s2 && $past(q_r.cs_s2)))
		else $error("data pin driven outside readback");
	a_frame_start: assert property (q_r.state == acr_pkg::ST_IDLE && !q_r.cs_s2 && sck_rise
		|=> q_r.state == acr_pkg::ST_INSTR) // R23
		else $error("frame did not start on first rise");
	a_dcs_strap_use: assert property (q_r.strap_done && !q_r.spi_used
		|=> q_r.dcs_o == $past(q_r.dcs_strap)) // R05
		else $error("stabilizer does not follow strap");
	a_fmt_strap_use: assert property (q_r.strap_done && !q_r.spi_used
		|=> q_r.twos_o == $past(q_r.fmt_strap)) // R06
		else $error("format does not follow strap");
	a_hiz_pin: assert property (output_enable_n_i ##1 output_enable_n_i ##1 output_enable_n_i
		|=> outputs_hiz_o) // R07
		else $error("outputs not high impedance");
	a_power_down_pin_pin: assert property (power_down_pin_i ##1 power_down_pin_i ##1 power_down_pin_i
		|=> power_down_o) // R08
		else $error("power-down not applied");

endmodule

// ---- sim/acr_spi_host.sv ----
`timescale 1ns/1ps

module acr_spi_host (
	input  wire logic sd_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sd_o,
	output logic      sd_en_o
);

	initial begin
		sclk_o  = 1'b0;
		cs_n_o  = 1'b1;
		sd_o    = 1'b1;
		sd_en_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strap levels held on the dual pins around reset
	task automatic strap(input logic duty_cycle_stabilizer, input logic fmt);
		sclk_o  = fmt;
		sd_o    = duty_cycle_stabilizer;
		sd_en_o = 1'b1;
	endtask

	// Serial clock stands low outside frames
	task automatic idle();
		sclk_o = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// One single-byte frame; address and data are sent as given, with no check against the map
	task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
		output logic [7:0] rdat);
		logic [23:0] sh;
		int          i;
		sh   = {rd, 2'h0, addr, wd};
		rdat = 8'h00;
		cs_n_o = 1'b0;
		for (i = 0; i < 24; i++) begin
			if (rd && i >= 16)
				sd_en_o = 1'b0;
			else
				sd_o = sh[23-i];
			#125;
			sclk_o = 1'b1;
			if (rd && i >= 16)
				rdat = {rdat[6:0], sd_i};
			#75;
			sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
		// Gap before taking the pin back avoids contention with a late release
		#200;
		sd_en_o = 1'b1;
	endtask

endmodule

// ---- sim/acr_config_bank_bench.sv ----
`timescale 1ns/1ps

module acr_config_bank_bench;

	logic         sys_clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         oe_pin  = 1'b0;
	logic         pd_pin  = 1'b0;
	logic         junk    = 1'b0;
	logic         sclk;
	logic         cs_n;
	logic         sd_host;
	logic         sd_en;
	logic         sd_out;
	logic         sd_oe_n;
	logic         sd_wire;
	logic         duty_cycle_stabilizer;
	logic         twos;
	logic         hiz;
	logic         pdn;
	logic         spi_act;
	logic [311:0] prog_a;
	logic [311:0] prog_b;
	logic [239:0] dig;
	int           mismatches   = 0;
	int           total_checks = 0;

	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) junk <= ~junk;

	// Released line shows a changing pattern
	assign sd_wire = !sd_oe_n ? sd_out : (sd_en ? sd_host : junk);

	acr_spi_host host (
		.sd_i    (sd_wire),
		.sclk_o  (sclk),
		.cs_n_o  (cs_n),
		.sd_o    (sd_host),
		.sd_en_o (sd_en)
	);

	acr_config_bank dut (
		.sys_clk_i                        (sys_clk),
		.sys_rst_i                        (sys_rst),
		.chip_select_n_i                  (cs_n),
		.clock_pin_format_strap_i         (sclk),
		.data_pin_stabilizer_strap_i      (sd_wire),
		.data_pin_stabilizer_strap_o      (sd_out),
		.data_pin_stabilizer_strap_oe_n_o (sd_oe_n),
		.output_enable_n_i                (oe_pin),
		.power_down_pin_i                 (pd_pin),
		.duty_cycle_stabilizer_o          (duty_cycle_stabilizer),
		.twos_complement_o                (twos),
		.outputs_hiz_o                    (hiz),
		.power_down_o                     (pdn),
		.spi_active_o                     (spi_act),
		.prog_a_o                         (prog_a),
		.prog_b_o                         (prog_b),
		.dig_o                            (dig)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] unused;
		host.frame(1'b0, a, d, unused);
		cycles(2);
	endtask

	task automatic rd(input logic [12:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.frame(1'b1, a, 8'h00, d);
		check("read data", exp, d);
	endtask

	task automatic do_reset(input logic s_dcs, input logic s_fmt);
		cycles(1);
		host.strap(s_dcs, s_fmt);
		sys_rst = 1'b1;
		cycles(10);
		sys_rst = 1'b0;
		cycles(8);
		host.idle();
		cycles(4);
		check("stabilizer", {7'h00, s_dcs}, {7'h00, duty_cycle_stabilizer});
		check("twos complement", {7'h00, s_fmt}, {7'h00, twos});
		check("spi active", 8'h00, {7'h00, spi_act});
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// No drive from the device while the host owns the pin
	always @(posedge sys_clk) begin
		if (!sys_rst && sd_oe_n === 1'b0 && sd_en === 1'b1) begin
			mismatches++;
			$display("unexpected data pin drive: expected %h, seen %h", 1'b1, sd_oe_n);
		end
	end

	initial begin
		#1000000;
		mismatches++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tests
	initial begin
		logic [1:0] v;
		do_reset(1'b0, 1'b1);
		do_reset(1'b1, 1'b0);
		for (v = 2'h0; v < 2'h2; v++) begin
			oe_pin = v[0];
			pd_pin = ~v[0];
			cycles(5);
			check("outputs hiz", {7'h00, v[0]}, {7'h00, hiz});
			check("power down", {7'h00, ~v[0]}, {7'h00, pdn});
		end
		pd_pin = 1'b0;
		rd(13'h0005, 8'h03);
		check("spi active", 8'h01, {7'h00, spi_act});
		check("stabilizer spi", 8'h00, {7'h00, duty_cycle_stabilizer});
		rd(13'h0000, 8'h18);
		rd(13'h0003, 8'h00);
		rd(13'h002E, 8'h00);
		wr(13'h0009, 8'h01);
		wr(13'h0014, 8'h01);
		check("active a 0x09", 8'h00, prog_a[8*1 +: 8]);
		check("stabilizer held", 8'h00, {7'h00, duty_cycle_stabilizer});
		check("twos held", 8'h00, {7'h00, twos});
		rd(13'h0009, 8'h01);
		wr(13'h00FF, 8'h01);
		check("active a 0x09", 8'h01, prog_a[8*1 +: 8]);
		check("active b 0x09", 8'h01, prog_b[8*1 +: 8]);
		check("active a 0x14", 8'h01, prog_a[8*12 +: 8]);
		check("stabilizer spi", 8'h01, {7'h00, duty_cycle_stabilizer});
		check("twos spi", 8'h01, {7'h00, twos});
		wr(13'h000A, 8'h44);
		check("active a 0x0A", 8'h00, prog_a[8*2 +: 8]);
		wr(13'h0005, 8'h01);
		wr(13'h0020, 8'h5A);
		check("chan a 0x20", 8'h5A, prog_a[8*24 +: 8]);
		check("chan b 0x20", 8'h00, prog_b[8*24 +: 8]);
		wr(13'h0005, 8'h02);
		wr(13'h0020, 8'hC3);
		check("chan b 0x20", 8'hC3, prog_b[8*24 +: 8]);
		check("chan a 0x20", 8'h5A, prog_a[8*24 +: 8]);
		rd(13'h0020, 8'hC3);
		wr(13'h002E, 8'h11);
		check("chan b 0x2E", 8'h11, prog_b[8*38 +: 8]);
		wr(13'h0100, 8'h77);
		wr(13'h011D, 8'h3C);
		check("digital 0x100", 8'h77, dig[8*0 +: 8]);
		check("digital 0x11D", 8'h3C, dig[8*29 +: 8]);
		wr(13'h0005, 8'h03);
		rd(13'h0020, 8'h5A);
		rd(13'h0100, 8'h77);
		wr(13'h0005, 8'h01);
		wr(13'h0000, 8'h24);
		rd(13'h0005, 8'h03);
		check("chan a 0x20 soft reset", 8'h00, prog_a[8*24 +: 8]);
		check("active a 0x09 kept", 8'h01, prog_a[8*1 +: 8]);
		rd(13'h0000, 8'h18);
		rd(13'h0100, 8'h00);
		summarize();
	end

endmodule
